/* shared/mac_tx_pkg.sv */
// shared constants, register layout and carriers for the frame transmit controller
package mac_tx_pkg;

   localparam int APB_AW = 8;
   localparam int APB_DW = 32;

   // register byte offsets
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_HDR = 8'h04;
   localparam logic [APB_AW-1:0] OFS_RADIO = 8'h08;
   localparam logic [APB_AW-1:0] OFS_FLEN = 8'h0c;
   localparam logic [APB_AW-1:0] OFS_DATA = 8'h10;
   localparam logic [APB_AW-1:0] OFS_STAT = 8'h14;

   // control register bits
   localparam int CTRL_START = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_DDR = 2;
   localparam int CTRL_PAR = 3;
   localparam int CTRL_RNG = 4;
   localparam int CTRL_CLRPTR = 5;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // header register fields
   localparam int HDR_LEN_LSB = 0;
   localparam int HDR_LEN_W = 14;
   localparam int HDR_RATE_LSB = 14;
   localparam int HDR_RATE_W = 5;
   localparam int HDR_HOP_LSB = 19;
   localparam int HDR_HOP_W = 4;
   localparam int HDR_BAND_BIT = 23;
   localparam int HDR_W = 24;
   localparam logic [HDR_W-1:0] HDR_RESET = 24'h000000;

   // radio register fields
   localparam int RADIO_CHAN_LSB = 0;
   localparam int RADIO_ANT_LSB = 4;
   localparam int RADIO_PWR_LSB = 8;
   localparam logic [11:0] RADIO_RESET = 12'h000;

   // interface_config bit that selects double-edge transfers
   localparam int IFCFG_DDR_BIT = 1;

   localparam logic [15:0] FLEN_RESET = 16'h0000;
   localparam logic [1:0] SEED_RESET = 2'h0;
   localparam logic [15:0] HDR_OCTETS = 16'h0004;

   // timing, counted in phy_clock rising edges unless noted
   localparam logic [1:0] DRIVE_EDGES = 2'h3;
   localparam logic [1:0] RELEASE_EDGES = 2'h2;
   localparam int SYS_CLK_NS = 40;
   localparam int RET_LEAD_NS = 80;
   localparam int RET_LEAD_CYC = (RET_LEAD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_RELEASE = 2'b11,
      ST_AIR_WAIT = 2'b10
   } tx_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [APB_AW-1:0] paddr;
      logic [APB_DW-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [APB_DW-1:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic transmit_request;
      logic receive_request;
      logic octet_valid;
      logic [7:0] data_out;
      logic data_oe;
      logic mac_return_clock;
   } phy_ctl_t;

   typedef struct packed {
      logic tx_preamble_select;
      logic [1:0] tx_antenna_select;
      logic [3:0] tx_channel_select;
      logic [3:0] tx_power_index;
      logic ranging_capture_enable;
      logic [7:0] interface_config;
   } radio_cfg_t;

endpackage

/* rtl/mac_tx_ctrl.sv */
// frame transmit controller: drives one frame at a time into the radio over the octet bus
// Function
// - one octet per cycle by default; both edges when interface_config bit 1 set
// - serial management: drive data bus three clocks after raising transmit_request
// - serial management: release data bus two clocks after lowering transmit_request
// - scrambler seed is a 2-bit count incremented modulo four per frame
// - single frames carry zero burst_flag and zero preamble_type_flag
// - rate field uses a defined code, forced to zero for zero length
// - header length field gives payload octets, 0 to 16383
// - tx_preamble_select is zero, standard preamble, for single frames
// - ranging_capture_enable zero unless ranging supported; then software chooses
// - raising transmit_request with receive_request low starts transmission
// - start should lead on-air timing by tx_path_latency
// - octet with octet_valid follows octet_request by two clock cycles
// - exactly one valid octet per request; requests sampled per active edge
// - data and octet_valid are timed on mac_return_clock
// - lower transmit_request at rising edge after last octet transferred
// - mac_return_clock runs through the frame plus one cycle
// - lowering transmit_request before last octet aborts the frame
`timescale 1ns/1ps
`default_nettype none

module mac_tx_ctrl #(
   parameter int BUF_WORDS = 256
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire mac_tx_pkg::apb_req_t apb_req,
   output var mac_tx_pkg::apb_rsp_t apb_rsp,
   input wire logic phy_clock,
   input wire logic octet_request,
   input wire logic air_activity,
   input wire logic [7:0] data_in,
   input wire logic ranging_capability,
   output var mac_tx_pkg::phy_ctl_t phy_ctl,
   output var mac_tx_pkg::radio_cfg_t radio_cfg
);
   import mac_tx_pkg::*;

   localparam int BW = $clog2(BUF_WORDS);

   // header octet layout: seed, flags, hop code / band, rate / length low / length high
   function automatic logic [7:0] hdr_octet(input logic [1:0] sel,
                                            input logic [HDR_W-1:0] h,
                                            input logic [1:0] sd);
      logic [HDR_LEN_W-1:0] len;
      logic [HDR_RATE_W-1:0] rate;
      logic [7:0] o;
      len = h[HDR_LEN_LSB +: HDR_LEN_W];
      // a zero-length frame has no payload rate
      rate = (len == '0) ? '0 : h[HDR_RATE_LSB +: HDR_RATE_W];
      unique case (sel)
         2'h0: o = {sd, 1'b0, 1'b0, h[HDR_HOP_LSB +: HDR_HOP_W]};
         2'h1: o = {h[HDR_BAND_BIT], 2'b00, rate};
         2'h2: o = len[7:0];
         2'h3: o = {2'b00, len[13:8]};
      endcase
      return o;
   endfunction

   function automatic logic reg_hit(input logic [APB_AW-1:0] a);
      return (a == OFS_CTRL) || (a == OFS_HDR) || (a == OFS_RADIO) ||
             (a == OFS_FLEN) || (a == OFS_DATA) || (a == OFS_STAT);
   endfunction

   // reset release
   logic [1:0] rst_pipe_r;
   logic rst_sync_b;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_r <= 2'b00;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe_r[1];

   // pin synchronisers: bit 0 phy_clock, bit 1 octet_request, bit 2 air_activity
   logic [2:0] pin_raw;
   logic [2:0] sy1_r, sy2_r, sy3_r, lvl_r, lvl_nxt;
   logic pclk_rise, pclk_fall, act_edge, req_lvl, air_lvl;

   assign pin_raw = {air_activity, octet_request, phy_clock};

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sy1_r <= 3'h0;
         sy2_r <= 3'h0;
         sy3_r <= 3'h0;
         lvl_r <= 3'h0;
      end else begin
         sy1_r <= pin_raw;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // a level moves only once the second and third stages agree
   assign lvl_nxt = (sy2_r & sy3_r) | (lvl_r & (sy2_r | sy3_r));
   assign pclk_rise = lvl_nxt[0] & ~lvl_r[0];
   assign pclk_fall = ~lvl_nxt[0] & lvl_r[0];
   assign req_lvl = lvl_nxt[1];
   assign air_lvl = lvl_r[2];

   // configuration and command registers
   logic ddr_r, par_r, rng_r;
   logic [HDR_W-1:0] hdr_r;
   logic [11:0] radio_r;
   logic [15:0] flen_r;
   logic start_p, abort_p, clrptr_p, wr_acc, wr_data;
   logic [APB_DW-1:0] buf_mem [BUF_WORDS];
   logic [BW-1:0] wptr_r;
   tx_state_t state_r;

   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & reg_hit(apb_req.paddr);
   assign start_p = wr_acc & (apb_req.paddr == OFS_CTRL) & apb_req.pwdata[CTRL_START];
   assign abort_p = wr_acc & (apb_req.paddr == OFS_CTRL) & apb_req.pwdata[CTRL_ABORT];
   assign clrptr_p = wr_acc & (apb_req.paddr == OFS_CTRL) & apb_req.pwdata[CTRL_CLRPTR];
   // frame setup is frozen while a frame is in flight
   assign wr_data = wr_acc & (apb_req.paddr == OFS_DATA) & (state_r == ST_IDLE);

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         {rng_r, par_r, ddr_r} <= CTRL_RESET;
         hdr_r <= HDR_RESET;
         radio_r <= RADIO_RESET;
         flen_r <= FLEN_RESET;
      end else if (wr_acc && state_r == ST_IDLE) begin
         unique case (apb_req.paddr)
            OFS_CTRL: begin
               ddr_r <= apb_req.pwdata[CTRL_DDR];
               par_r <= apb_req.pwdata[CTRL_PAR];
               rng_r <= apb_req.pwdata[CTRL_RNG];
            end
            OFS_HDR: hdr_r <= apb_req.pwdata[HDR_W-1:0];
            OFS_RADIO: radio_r <= apb_req.pwdata[11:0];
            OFS_FLEN: flen_r <= apb_req.pwdata[15:0];
            default: ;
         endcase
      end
   end

   // octet buffer holding the frame body after the header, four octets a word
   always_ff @(posedge clk_sys) begin
      if (wr_data) begin
         buf_mem[wptr_r] <= apb_req.pwdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wptr_r <= '0;
      end else if (clrptr_p && state_r == ST_IDLE) begin
         wptr_r <= '0;
      end else if (wr_data) begin
         wptr_r <= wptr_r + 1'b1;
      end
   end

   // frame sequencing
   logic txreq_r, oe_r, done_r, aborted_r;
   logic [1:0] edge_cnt_r, seed_r;
   logic [15:0] idx_r, total;
   logic all_sent;

   assign total = HDR_OCTETS + flen_r;
   assign all_sent = (idx_r == total);

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_r <= ST_IDLE;
         txreq_r <= 1'b0;
         oe_r <= 1'b0;
         edge_cnt_r <= 2'h0;
         seed_r <= SEED_RESET;
         done_r <= 1'b0;
         aborted_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               // software times the start to lead the air slot by the radio latency
               if (start_p) begin
                  state_r <= ST_SEND;
                  txreq_r <= 1'b1;
                  seed_r <= seed_r + 2'h1;
                  edge_cnt_r <= 2'h0;
                  done_r <= 1'b0;
                  aborted_r <= 1'b0;
               end
            end
            ST_SEND: begin
               if (pclk_rise && !oe_r) begin
                  edge_cnt_r <= edge_cnt_r + 2'h1;
                  if (edge_cnt_r == DRIVE_EDGES - 2'h1) begin
                     oe_r <= 1'b1;
                  end
               end
               if (abort_p && !all_sent) begin
                  txreq_r <= 1'b0;
                  aborted_r <= 1'b1;
                  state_r <= ST_RELEASE;
                  edge_cnt_r <= 2'h0;
               end else if (pclk_rise && all_sent) begin
                  // the edge after the last octet went out
                  txreq_r <= 1'b0;
                  state_r <= ST_RELEASE;
                  edge_cnt_r <= 2'h0;
               end
            end
            ST_RELEASE: begin
               if (pclk_rise) begin
                  edge_cnt_r <= edge_cnt_r + 2'h1;
                  if (edge_cnt_r == RELEASE_EDGES - 2'h1) begin
                     oe_r <= 1'b0;
                     state_r <= ST_AIR_WAIT;
                  end
               end
            end
            ST_AIR_WAIT: begin
               // the radio leaves transmit when air activity ends
               if (!air_lvl) begin
                  state_r <= ST_IDLE;
                  done_r <= ~aborted_r;
               end
            end
         endcase
      end
   end

   // octet supply: requests age through a pipe of active edges
   logic [3:0] req_pipe_r;
   logic valid_r, tap, load;
   logic [7:0] data_r, next_octet;
   logic [15:0] bidx, extra_r;

   // double-edge mode counts both edges, so two cycles span four active edges
   assign act_edge = pclk_rise | (ddr_r & pclk_fall);
   assign tap = ddr_r ? req_pipe_r[3] : req_pipe_r[1];
   assign load = tap & txreq_r & !all_sent;
   assign bidx = idx_r - HDR_OCTETS;
   assign next_octet = (idx_r < HDR_OCTETS) ? hdr_octet(idx_r[1:0], hdr_r, seed_r) :
                       buf_mem[bidx[BW+1:2]][8*bidx[1:0] +: 8];

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         req_pipe_r <= 4'h0;
         valid_r <= 1'b0;
         data_r <= 8'h00;
         idx_r <= 16'h0000;
         extra_r <= 16'h0000;
      end else if (state_r == ST_IDLE) begin
         req_pipe_r <= 4'h0;
         valid_r <= 1'b0;
         if (start_p) begin
            idx_r <= 16'h0000;
            extra_r <= 16'h0000;
         end
      end else if (act_edge) begin
         req_pipe_r <= {req_pipe_r[2:0], req_lvl & txreq_r};
         // one octet per request, never once transmit_request is down
         valid_r <= load;
         if (load) begin
            data_r <= next_octet;
            idx_r <= idx_r + 16'h0001;
         end else if (tap) begin
            extra_r <= extra_r + 16'h0001;
         end
      end
   end

   // returned clock: a delayed copy of the filtered phy_clock, so data leads it
   logic [RET_LEAD_CYC-1:0] ret_r;

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ret_r <= '0;
      end else begin
         ret_r <= {ret_r[RET_LEAD_CYC-2:0], lvl_r[0]};
      end
   end

   // register read path, captured in the setup phase so prdata comes from a flop
   logic [APB_DW-1:0] rdata_r, rd_mux;

   always_comb begin
      rd_mux = '0;
      unique case (apb_req.paddr)
         OFS_CTRL: begin
            rd_mux[CTRL_DDR] = ddr_r;
            rd_mux[CTRL_PAR] = par_r;
            rd_mux[CTRL_RNG] = rng_r;
         end
         OFS_HDR: rd_mux[HDR_W-1:0] = hdr_r;
         OFS_RADIO: rd_mux[11:0] = radio_r;
         OFS_FLEN: rd_mux[15:0] = flen_r;
         OFS_DATA: rd_mux[BW-1:0] = wptr_r;
         OFS_STAT: rd_mux = {idx_r, extra_r[7:0], 1'b0, seed_r, aborted_r, done_r,
                             air_lvl, state_r};
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_r <= '0;
      end else if (apb_req.psel && !apb_req.penable) begin
         rdata_r <= rd_mux;
      end
   end

   always_comb begin
      apb_rsp.prdata = rdata_r;
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~reg_hit(apb_req.paddr);
   end

   // pins and radio settings
   always_comb begin
      phy_ctl.transmit_request = txreq_r;
      phy_ctl.receive_request = 1'b0;
      phy_ctl.octet_valid = valid_r;
      phy_ctl.data_out = data_r;
      // parallel management keeps the bus outside receive, which this block never enters
      phy_ctl.data_oe = par_r | oe_r;
      phy_ctl.mac_return_clock = ret_r[RET_LEAD_CYC-1];
      radio_cfg.tx_preamble_select = 1'b0;
      radio_cfg.tx_antenna_select = radio_r[RADIO_ANT_LSB +: 2];
      radio_cfg.tx_channel_select = radio_r[RADIO_CHAN_LSB +: 4];
      radio_cfg.tx_power_index = radio_r[RADIO_PWR_LSB +: 4];
      radio_cfg.ranging_capture_enable = rng_r & ranging_capability;
      radio_cfg.interface_config = 8'h00;
      radio_cfg.interface_config[IFCFG_DDR_BIT] = ddr_r;
   end

endmodule

`default_nettype wire

/* verif/mac_tx_ctrl_properties.sv */
// port checker for the frame transmit controller
`timescale 1ns/1ps
`default_nettype none
module mac_tx_ctrl_properties (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire mac_tx_pkg::apb_req_t apb_req,
   input wire mac_tx_pkg::apb_rsp_t apb_rsp,
   input wire logic phy_clock,
   input wire logic octet_request,
   input wire logic air_activity,
   input wire logic [7:0] data_in,
   input wire logic ranging_capability,
   input wire mac_tx_pkg::phy_ctl_t phy_ctl,
   input wire mac_tx_pkg::radio_cfg_t radio_cfg
);
   import mac_tx_pkg::*;
   logic txd_r;
   logic ser_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // parallel mode keeps the bus driven, so bus hand-over is only judged in serial frames
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         txd_r <= 1'b0;
         ser_r <= 1'b0;
      end else begin
         txd_r <= phy_ctl.transmit_request;
         if (phy_ctl.transmit_request && !txd_r) ser_r <= !phy_ctl.data_oe;
      end
   end
   rx_low_a: assert property (!phy_ctl.receive_request)
      else $error("receive request raised");
   std_preamble_a: assert property (!radio_cfg.tx_preamble_select)
      else $error("preamble select not standard");
   rng_gate_a: assert property (radio_cfg.ranging_capture_enable |-> ranging_capability)
      else $error("ranging enabled without capability");
   cfg_bits_a: assert property (radio_cfg.interface_config[7:2] == 6'h00
      && !radio_cfg.interface_config[0])
      else $error("stray interface config bits");
   oe_late_a: assert property ($rose(phy_ctl.transmit_request) && !phy_ctl.data_oe
      |-> !phy_ctl.data_oe[*8])
      else $error("bus driven too early");
   oe_soon_a: assert property ($rose(phy_ctl.transmit_request) && !phy_ctl.data_oe
      |-> ##[12:48] phy_ctl.data_oe)
      else $error("bus not driven in time");
   oe_hold_a: assert property ($fell(phy_ctl.transmit_request) && ser_r
      |-> phy_ctl.data_oe[*4])
      else $error("bus released too early");
   oe_free_a: assert property ($fell(phy_ctl.transmit_request) && ser_r
      |-> ##[6:30] !phy_ctl.data_oe)
      else $error("bus not released");
   valid_bus_a: assert property (phy_ctl.octet_valid |-> phy_ctl.data_oe)
      else $error("valid octet on undriven bus");
   req_answer_a: assert property ($rose(octet_request) && phy_ctl.transmit_request
      && !radio_cfg.interface_config[1] |-> ##[10:40] phy_ctl.octet_valid)
      else $error("request not answered");
   ret_clock_a: assert property ($rose(phy_clock) && phy_ctl.transmit_request
      |-> ##[1:8] $rose(phy_ctl.mac_return_clock))
      else $error("return clock not following");
endmodule
bind mac_tx_ctrl mac_tx_ctrl_properties chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .phy_clock(phy_clock),
   .octet_request(octet_request), .air_activity(air_activity), .data_in(data_in),
   .ranging_capability(ranging_capability), .phy_ctl(phy_ctl), .radio_cfg(radio_cfg));
`default_nettype wire

/* verif/radio_model.sv */
// behavioural radio: free-running clock, octet requests, air activity
`timescale 1ns/1ps
`default_nettype none
module radio_model #(
   parameter int HALF_NS = 160
) (
   input wire mac_tx_pkg::phy_ctl_t phy_ctl,
   input wire mac_tx_pkg::radio_cfg_t radio_cfg,
   input wire logic [15:0] n_oct,
   input wire logic [3:0] gap,
   output logic phy_clock,
   output logic octet_request,
   output logic air_activity,
   output logic [7:0] data_in
);
   import mac_tx_pkg::*;
   logic [7:0] got[$];
   logic [31:0] ranging_timestamp;
   logic [31:0] stamp = 32'h0;
   wire logic ddr = radio_cfg.interface_config[IFCFG_DDR_BIT];
   // radio never drives in transmit; inverse data keeps stale values off the input
   assign data_in = ~phy_ctl.data_out;
   initial begin
      phy_clock = 1'b0;
      forever #(HALF_NS) phy_clock = ~phy_clock;
   end
   always @(posedge phy_clock) stamp <= stamp + 32'h1;
   task automatic step(input int n);
      repeat (n) begin
         if (ddr) @(phy_clock);
         else @(posedge phy_clock);
      end
   endtask
   initial begin
      octet_request = 1'b0;
      air_activity = 1'b0;
      forever begin
         @(posedge phy_clock);
         if (!phy_ctl.transmit_request) continue;
         repeat (2) @(posedge phy_clock);
         air_activity = 1'b1;
         if (radio_cfg.ranging_capture_enable) ranging_timestamp = stamp;
         repeat (2) @(posedge phy_clock);
         for (int i = 0; i < n_oct && phy_ctl.transmit_request; i++) begin
            octet_request = 1'b1;
            step(1);
            octet_request = 1'b0;
            step(gap);
         end
         while (phy_ctl.transmit_request) @(posedge phy_clock);
         repeat (3) @(posedge phy_clock);
         air_activity = 1'b0;
      end
   end
   // returned clock is only trusted while the frame is on
   always @(posedge phy_ctl.mac_return_clock)
      if (air_activity && phy_ctl.octet_valid) got.push_back(phy_ctl.data_out);
   always @(negedge phy_ctl.mac_return_clock)
      if (air_activity && ddr && phy_ctl.octet_valid) got.push_back(phy_ctl.data_out);
endmodule
`default_nettype wire

/* verif/testbench.sv */
// register-level tests of the frame transmit controller against the radio model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mac_tx_pkg::*;
   logic clk_sys;
   logic rst_b;
   apb_req_t apb_req;
   apb_rsp_t apb_rsp;
   logic phy_clock;
   logic octet_request;
   logic air_activity;
   logic [7:0] data_in;
   logic ranging_capability;
   phy_ctl_t phy_ctl;
   radio_cfg_t radio_cfg;
   logic [15:0] n_oct;
   logic [3:0] gap;
   logic [31:0] rd;
   logic er;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] pay [3] = '{32'h44332211, 32'h88776655, 32'hccbbaa99};
   mac_tx_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .phy_clock(phy_clock), .octet_request(octet_request), .air_activity(air_activity),
      .data_in(data_in), .ranging_capability(ranging_capability), .phy_ctl(phy_ctl),
      .radio_cfg(radio_cfg));
   radio_model phy (.phy_ctl(phy_ctl), .radio_cfg(radio_cfg), .n_oct(n_oct), .gap(gap),
      .phy_clock(phy_clock), .octet_request(octet_request), .air_activity(air_activity),
      .data_in(data_in));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // one frame from setup to idle; the abort variant cuts it after six octets
   task automatic frame(input logic [31:0] m, input logic [23:0] h, input logic [1:0] sd,
                        input logic ab);
      logic [7:0] e[$];
      logic [13:0] l;
      l = h[13:0];
      apb(1'b1, OFS_CTRL, m | (32'h1 << CTRL_CLRPTR));
      apb(1'b1, OFS_HDR, {8'h00, h});
      apb(1'b1, OFS_FLEN, {18'h0, l});
      for (int i = 0; i < l; i += 4) apb(1'b1, OFS_DATA, pay[i/4]);
      e.push_back({sd, 2'b00, h[22:19]});
      e.push_back({h[23], 2'b00, (l == 14'h0) ? 5'h00 : h[18:14]});
      e.push_back(l[7:0]);
      e.push_back({2'b00, l[13:8]});
      for (int i = 0; i < l; i++) e.push_back(pay[i/4][8*(i%4) +: 8]);
      n_oct <= 16'h4 + {2'b00, l};
      phy.got.delete();
      apb(1'b1, OFS_CTRL, m | (32'h1 << CTRL_START));
      if (ab) begin
         wait (phy.got.size() > 5);
         apb(1'b1, OFS_CTRL, m | (32'h1 << CTRL_ABORT));
      end
      repeat (2000) begin
         apb(1'b0, OFS_STAT, 32'h0);
         if (rd[1:0] == 2'b00) break;
      end
      // a hang in any state other than idle must not slip through
      chk(rd[4:0], {ab, !ab, 3'b000});
      chk(rd[6:5], sd);
      chk(phy_ctl.transmit_request, 1'b0);
      if (ab) chk({rd[4], phy.got.size() < e.size()}, 2'b11);
      else begin
         chk(rd[15:8], 8'h00);
         chk(phy.got.size(), e.size());
         foreach (e[i]) chk(phy.got[i], e[i]);
      end
   endtask
   initial begin
      rst_b = 1'b0;
      apb_req = '0;
      ranging_capability = 1'b0;
      n_oct = 16'h0;
      gap = 4'h0;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdc(OFS_HDR, 32'h0);
      rdc(OFS_RADIO, 32'h0);
      rdc(OFS_FLEN, 32'h0);
      rdc(OFS_STAT, 32'h0);
      rdc(8'h18, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, OFS_RADIO, 32'h00000a25);
      // the write lands at the edge that ends the access, so look one edge later
      @(posedge clk_sys);
      chk({radio_cfg.tx_power_index, 2'b00, radio_cfg.tx_antenna_select,
           radio_cfg.tx_channel_select}, 32'ha25);
      chk(radio_cfg.tx_preamble_select, 1'b0);
      frame(32'h1 << CTRL_RNG, {1'b1, 4'h3, 5'h0b, 14'd5}, 2'h1, 1'b0);
      chk(radio_cfg.ranging_capture_enable, 1'b0);
      ranging_capability <= 1'b1;
      frame((32'h1 << CTRL_DDR) | (32'h1 << CTRL_RNG),
            {1'b0, 4'h9, 5'h13, 14'd0}, 2'h2, 1'b0);
      chk(radio_cfg.interface_config, 8'h02);
      chk(radio_cfg.ranging_capture_enable, 1'b1);
      gap <= 4'h2;
      frame(32'h1 << CTRL_DDR, {1'b0, 4'h5, 5'h17, 14'd12}, 2'h3, 1'b1);
      gap <= 4'h0;
      frame(32'h1 << CTRL_PAR, {1'b1, 4'hf, 5'h17, 14'd1}, 2'h0, 1'b0);
      chk(phy_ctl.data_oe, 1'b1);
      rdc(OFS_CTRL, 32'h1 << CTRL_PAR);
      rdc(OFS_DATA, 32'h1);
      test_done;
   end
endmodule
`default_nettype wire
